// >>> rtl/port_mode_pkg.sv
package port_mode_pkg;

	// ----------------------------------------------------------------
	// register addresses and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PORT1_DATA_LATCH    = 8'h90;
	localparam logic [7:0] ADDR_PORT1_PIN_MODE_LOW  = 8'hA2;
	localparam logic [7:0] ADDR_PORT1_PIN_MODE_HIGH = 8'hA3;
	localparam logic [7:0] ADDR_PORT3_PIN_MODE_LOW  = 8'hA4;
	localparam logic [7:0] ADDR_PORT3_PIN_MODE_HIGH = 8'hA5;
	localparam logic [7:0] ADDR_PORT3_DATA_LATCH    = 8'hB0;

	localparam logic [7:0] RST_PORT1_DATA_LATCH    = 8'hFF;
	localparam logic [7:0] RST_PORT1_PIN_MODE_LOW  = 8'h00;
	localparam logic [7:0] RST_PORT1_PIN_MODE_HIGH = 8'h00;
	localparam logic [7:0] RST_PORT3_PIN_MODE_LOW  = 8'h33;
	localparam logic [7:0] RST_PORT3_PIN_MODE_HIGH = 8'h00;
	localparam logic [7:0] RST_PORT3_DATA_LATCH    = 8'hFF;

	// ----------------------------------------------------------------
	// mode field codes and pin positions (pins 0-7 port 1, 8-15 port 3)
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_OPEN_DRAIN_PULLUP = 2'h0;
	localparam logic [1:0] MODE_OPEN_DRAIN_HIZ    = 2'h1;
	localparam logic [1:0] MODE_PUSH_PULL         = 2'h2;
	localparam logic [1:0] MODE_ALTERNATE         = 2'h3;

	localparam int PIN_TIMER2_OUT   = 0;
	localparam int PIN_LCD_SEG_B    = 8;
	localparam int PIN_LCD_SEG_A    = 10;
	localparam int PIN_TIMER1_OUT   = 13;
	localparam int PIN_TIMER1_INV   = 14;
	localparam int PIN_SYSTEM_CLOCK_OUT   = 15;
	localparam int PIN_QUASI_FIRST  = 8;
	localparam int QUASI_PIN_COUNT  = 3;
	localparam int TOUCH_LOW_COUNT  = 10;
	localparam int TOUCH_HIGH_COUNT = 4;
	// pin index of each touch channel, channel 0 first
	localparam int TOUCH_PIN [14] = '{7, 6, 5, 4, 3, 2, 1, 12, 11, 9, 0, 15, 14, 13};

	// strong high drive time of a quasi-bidirectional pin, in clock cycles
	localparam logic [1:0] PSEUDO_BOOST_CYCLES = 2'h2;
	localparam logic [2:0] CLK_DIV_MIN         = 3'h1;

	// field of pin n out of a packed {high,low} mode pair
	function automatic logic [1:0] mode_of(input logic [15:0] modes, input int n);
		return modes[2*n +: 2];
	endfunction

	// timer overflow divider select: 0 -> 2, 1 -> 3, else 4
	function automatic logic [2:0] timer_div_n(input logic [1:0] sel);
		return (sel == 2'h0) ? 3'h2 : ((sel == 2'h1) ? 3'h3 : 3'h4);
	endfunction

endpackage

// >>> rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
	import port_mode_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta;

	// ----------------------------------------------------------------
	// two-stage synchroniser; the first stage feeds only the second
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta   <= '0;
			o_sync <= '0;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule

// >>> rtl/tick_divider.sv
`timescale 1ns/1ps
module tick_divider
	import port_mode_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_tick,
	input  wire logic [2:0] i_div_n,
	output logic            o_wave
);

	logic [2:0] count;
	logic [2:0] next_count;

	// wrap after n ticks; a smaller n written mid-count wraps at once
	always_comb begin
		next_count = count;
		if (i_tick) begin
			next_count = (count >= i_div_n - 3'h1) ? 3'h0 : count + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// wave is high for the upper half of each count cycle
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			count  <= 3'h0;
			o_wave <= 1'b0;
		end else begin
			count  <= next_count;
			o_wave <= (next_count >= {1'b0, i_div_n[2:1]});
		end
	end

endmodule

// >>> rtl/quasi_bidir_port_mode_ctrl.sv
`timescale 1ns/1ps
module quasi_bidir_port_mode_ctrl
	import port_mode_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic [7:0]  i_sfr_wdata,
	input  wire logic        i_sfr_wr,
	input  wire logic        i_sfr_rd,
	input  wire logic        i_sfr_rmw,
	output logic      [7:0]  o_sfr_rdata,
	input  wire logic [7:0]  i_p1_pin,
	input  wire logic [7:0]  i_p3_pin,
	output logic      [7:0]  o_p1_out,
	output logic      [7:0]  o_p1_oe,
	output logic      [7:0]  o_p1_pullup,
	output logic      [7:0]  o_p1_din_en,
	output logic      [7:0]  o_p3_out,
	output logic      [7:0]  o_p3_oe,
	output logic      [7:0]  o_p3_pullup,
	output logic      [7:0]  o_p3_din_en,
	output logic      [7:0]  o_p1_digital_in,
	output logic      [7:0]  o_p3_digital_in,
	input  wire logic        i_timer2_overflow,
	input  wire logic        i_timer1_overflow,
	input  wire logic [1:0]  i_timer2_div_sel,
	input  wire logic [1:0]  i_timer1_div_sel,
	input  wire logic [1:0]  i_system_clock_div_sel,
	input  wire logic        i_lcd_segment_a,
	input  wire logic        i_lcd_segment_b,
	output logic      [9:0]  o_touch_key_channels_low,
	output logic      [3:0]  o_touch_key_channels_high,
	output logic      [13:0] o_touch_key_scan
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0]  port1_data_latch;
	logic [7:0]  port3_data_latch;
	logic [7:0]  port1_pin_mode_low;
	logic [7:0]  port1_pin_mode_high;
	logic [7:0]  port3_pin_mode_low;
	logic [7:0]  port3_pin_mode_high;
	logic [15:0] pin_level;
	logic [15:0] latch_all;
	logic [31:0] mode_all;
	logic [2:0]  quasi_latch_q;
	logic [1:0]  boost_cnt [QUASI_PIN_COUNT];
	logic [2:0]  quasi_rise;
	logic        timer2_divided_overflow_out;
	logic        timer1_divided_overflow_out;
	logic        system_clock_divided_out;
	logic        system_clock_bypass;
	logic [15:0] alt_drive;
	logic [15:0] alt_value;
	logic [15:0] next_out;
	logic [15:0] next_oe;
	logic [15:0] next_pullup;
	logic [15:0] next_din_en;
	logic [15:0] pin_out_q;
	logic [7:0]  next_rdata;
	logic [13:0] next_scan;

	assign latch_all = {port3_data_latch, port1_data_latch};
	assign mode_all  = {port3_pin_mode_high, port3_pin_mode_low, port1_pin_mode_high, port1_pin_mode_low};

	// ----------------------------------------------------------------
	// pin sampling and alternative function sources
	// ----------------------------------------------------------------
	pin_sync #(
		.WIDTH (16)
	) u_pin_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_async  ({i_p3_pin, i_p1_pin}),
		.o_sync   (pin_level)
	);

	tick_divider u_timer2_div (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_tick   (i_timer2_overflow),
		.i_div_n  (timer_div_n(i_timer2_div_sel)),
		.o_wave   (timer2_divided_overflow_out)
	);

	tick_divider u_timer1_div (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_tick   (i_timer1_overflow),
		.i_div_n  (timer_div_n(i_timer1_div_sel)),
		.o_wave   (timer1_divided_overflow_out)
	);

	// counts every system clock; divide by one is taken straight from the clock
	tick_divider u_system_clock_div (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_tick   (1'b1),
		.i_div_n  (3'({1'b0, i_system_clock_div_sel}) + CLK_DIV_MIN),
		.o_wave   (system_clock_divided_out)
	);

	// ----------------------------------------------------------------
	// data latches: plain writes and read-modify-write write-backs land here
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			port1_data_latch <= RST_PORT1_DATA_LATCH;
			port3_data_latch <= RST_PORT3_DATA_LATCH;
		end else if (i_sfr_wr) begin
			if (i_sfr_addr == ADDR_PORT1_DATA_LATCH) begin
				port1_data_latch <= i_sfr_wdata;
			end
			if (i_sfr_addr == ADDR_PORT3_DATA_LATCH) begin
				port3_data_latch <= i_sfr_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// mode fields; port 3 low starts with both segment pins in mode 3
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			port1_pin_mode_low  <= RST_PORT1_PIN_MODE_LOW;
			port1_pin_mode_high <= RST_PORT1_PIN_MODE_HIGH;
			port3_pin_mode_low  <= RST_PORT3_PIN_MODE_LOW;
			port3_pin_mode_high <= RST_PORT3_PIN_MODE_HIGH;
		end else if (i_sfr_wr) begin
			unique case (i_sfr_addr)
				ADDR_PORT1_PIN_MODE_LOW:  port1_pin_mode_low  <= i_sfr_wdata;
				ADDR_PORT1_PIN_MODE_HIGH: port1_pin_mode_high <= i_sfr_wdata;
				ADDR_PORT3_PIN_MODE_LOW:  port3_pin_mode_low  <= i_sfr_wdata;
				ADDR_PORT3_PIN_MODE_HIGH: port3_pin_mode_high <= i_sfr_wdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read path: modify-type reads see the latch, plain reads see the pins
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		unique case (i_sfr_addr)
			ADDR_PORT1_DATA_LATCH:    next_rdata = i_sfr_rmw ? port1_data_latch : pin_level[7:0];
			ADDR_PORT3_DATA_LATCH:    next_rdata = i_sfr_rmw ? port3_data_latch : pin_level[15:8];
			ADDR_PORT1_PIN_MODE_LOW:  next_rdata = port1_pin_mode_low;
			ADDR_PORT1_PIN_MODE_HIGH: next_rdata = port1_pin_mode_high;
			ADDR_PORT3_PIN_MODE_LOW:  next_rdata = port3_pin_mode_low;
			ADDR_PORT3_PIN_MODE_HIGH: next_rdata = port3_pin_mode_high;
			default:                  next_rdata = 8'h00;
		endcase
	end

	// read data holds until the next read
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sfr_rdata <= 8'h00;
		end else if (i_sfr_rd) begin
			o_sfr_rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// quasi-bidirectional boost on port 3 bits 0-2
	// ----------------------------------------------------------------
	always_comb begin
		for (int q = 0; q < QUASI_PIN_COUNT; q++) begin
			quasi_rise[q] = port3_data_latch[q] & ~quasi_latch_q[q]
				& (mode_of(mode_all[31:16], q) <= MODE_OPEN_DRAIN_HIZ);
		end
	end

	// the rising edge itself is one strong cycle, the counter adds the rest
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			quasi_latch_q <= 3'h7;
			for (int q = 0; q < QUASI_PIN_COUNT; q++) begin
				boost_cnt[q] <= 2'h0;
			end
		end else begin
			quasi_latch_q <= port3_data_latch[2:0];
			for (int q = 0; q < QUASI_PIN_COUNT; q++) begin
				if (quasi_rise[q]) begin
					boost_cnt[q] <= PSEUDO_BOOST_CYCLES - 2'h1;
				end else if (boost_cnt[q] != 2'h0) begin
					boost_cnt[q] <= boost_cnt[q] - 2'h1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// alternative function drivers of mode 3
	// ----------------------------------------------------------------
	always_comb begin
		alt_drive = 16'h0000;
		alt_value = 16'h0000;
		alt_drive[PIN_TIMER2_OUT] = 1'b1;
		alt_value[PIN_TIMER2_OUT] = timer2_divided_overflow_out;
		alt_drive[PIN_LCD_SEG_B]  = 1'b1;
		alt_value[PIN_LCD_SEG_B]  = i_lcd_segment_b;
		alt_drive[PIN_LCD_SEG_A]  = 1'b1;
		alt_value[PIN_LCD_SEG_A]  = i_lcd_segment_a;
		alt_drive[PIN_TIMER1_OUT] = 1'b1;
		alt_value[PIN_TIMER1_OUT] = timer1_divided_overflow_out;
		alt_drive[PIN_TIMER1_INV] = 1'b1;
		alt_value[PIN_TIMER1_INV] = ~timer1_divided_overflow_out;
		alt_drive[PIN_SYSTEM_CLOCK_OUT] = 1'b1;
		alt_value[PIN_SYSTEM_CLOCK_OUT] = system_clock_divided_out;
	end

	// ----------------------------------------------------------------
	// per-pin drive decode; low touch channel pins are the mode 3 pins left undriven
	// ----------------------------------------------------------------
	always_comb begin
		for (int p = 0; p < 16; p++) begin
			next_out[p]    = 1'b0;
			next_oe[p]     = 1'b0;
			next_pullup[p] = 1'b0;
			next_din_en[p] = 1'b0;
			unique case (mode_of(mode_all[2*(p/8)*8 +: 16], p % 8))
				MODE_OPEN_DRAIN_PULLUP: begin
					next_oe[p]     = ~latch_all[p];
					next_pullup[p] = latch_all[p];
					next_din_en[p] = latch_all[p];
				end
				MODE_OPEN_DRAIN_HIZ: begin
					next_oe[p]     = ~latch_all[p];
					next_din_en[p] = latch_all[p];
				end
				MODE_PUSH_PULL: begin
					next_oe[p]  = 1'b1;
					next_out[p] = latch_all[p];
				end
				MODE_ALTERNATE: begin
					next_oe[p]  = alt_drive[p];
					next_out[p] = alt_value[p];
				end
			endcase
		end
		for (int q = 0; q < QUASI_PIN_COUNT; q++) begin
			if (quasi_rise[q] || boost_cnt[q] != 2'h0) begin
				next_oe[PIN_QUASI_FIRST + q]  = 1'b1;
				next_out[PIN_QUASI_FIRST + q] = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// registered pad controls and gated digital inputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_out_q       <= 16'h0000;
			o_p1_oe         <= 8'h00;
			o_p3_oe         <= 8'h00;
			o_p1_pullup     <= 8'h00;
			o_p3_pullup     <= 8'h00;
			o_p1_din_en     <= 8'h00;
			o_p3_din_en     <= 8'h00;
			o_p1_digital_in <= 8'h00;
			o_p3_digital_in <= 8'h00;
			system_clock_bypass   <= 1'b0;
		end else begin
			pin_out_q       <= next_out;
			{o_p3_oe, o_p1_oe}         <= next_oe;
			{o_p3_pullup, o_p1_pullup} <= next_pullup;
			{o_p3_din_en, o_p1_din_en} <= next_din_en;
			{o_p3_digital_in, o_p1_digital_in} <= pin_level & next_din_en;
			system_clock_bypass   <= (i_system_clock_div_sel == 2'h0)
				&& (mode_of(mode_all[31:16], PIN_SYSTEM_CLOCK_OUT - 8) == MODE_ALTERNATE);
		end
	end

	// divide by one cannot come from a flop, so the clock itself is gated onto the pin
	assign o_p1_out = pin_out_q[7:0];
	assign o_p3_out = system_clock_bypass ? {i_clk, pin_out_q[14:8]} : pin_out_q[15:8];

	// ----------------------------------------------------------------
	// touch key routing
	// ----------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < TOUCH_LOW_COUNT; c++) begin
			next_scan[c] = (mode_of(mode_all[2*(TOUCH_PIN[c]/8)*8 +: 16], TOUCH_PIN[c] % 8)
				== MODE_ALTERNATE);
		end
		for (int c = TOUCH_LOW_COUNT; c < TOUCH_LOW_COUNT + TOUCH_HIGH_COUNT; c++) begin
			next_scan[c] = (mode_of(mode_all[2*(TOUCH_PIN[c]/8)*8 +: 16], TOUCH_PIN[c] % 8)
				== MODE_OPEN_DRAIN_HIZ) && latch_all[TOUCH_PIN[c]];
		end
	end

	// sensed level is only passed on while its channel scans
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_touch_key_scan          <= 14'h0000;
			o_touch_key_channels_low  <= 10'h000;
			o_touch_key_channels_high <= 4'h0;
		end else begin
			o_touch_key_scan <= next_scan;
			for (int c = 0; c < TOUCH_LOW_COUNT; c++) begin
				o_touch_key_channels_low[c] <= next_scan[c] & pin_level[TOUCH_PIN[c]];
			end
			for (int c = 0; c < TOUCH_HIGH_COUNT; c++) begin
				o_touch_key_channels_high[c] <= next_scan[TOUCH_LOW_COUNT + c]
					& pin_level[TOUCH_PIN[TOUCH_LOW_COUNT + c]];
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_p1_rmw_read;
		i_sfr_rd && i_sfr_rmw && i_sfr_addr == ADDR_PORT1_DATA_LATCH;
	endsequence

	sequence s_p3_plain_read;
		i_sfr_rd && !i_sfr_rmw && i_sfr_addr == ADDR_PORT3_DATA_LATCH;
	endsequence

	property p_rmw_reads_latch;
		s_p1_rmw_read |=> o_sfr_rdata == $past(port1_data_latch);
	endproperty
	a_rmw_reads_latch: assert property (p_rmw_reads_latch) else $error("rmw read not from latch");

	property p_plain_read_pins;
		s_p3_plain_read |=> o_sfr_rdata == $past(pin_level[15:8]);
	endproperty
	a_plain_read_pins: assert property (p_plain_read_pins) else $error("plain read not from pins");

	property p_write_then_latch;
		i_sfr_wr && i_sfr_addr == ADDR_PORT3_DATA_LATCH |=> port3_data_latch == $past(i_sfr_wdata);
	endproperty
	a_write_then_latch: assert property (p_write_then_latch) else $error("latch write lost");

	property p_mode0_low;
		mode_of(mode_all[15:0], 7) == MODE_OPEN_DRAIN_PULLUP && !port1_data_latch[7]
			|=> o_p1_oe[7] && !o_p1_out[7] && !o_p1_pullup[7] && !o_p1_din_en[7];
	endproperty
	a_mode0_low: assert property (p_mode0_low) else $error("mode 0 low drive wrong");

	property p_mode1_float;
		mode_of(mode_all[15:0], 2) == MODE_OPEN_DRAIN_HIZ && port1_data_latch[2]
			|=> !o_p1_oe[2] && !o_p1_pullup[2] && o_p1_din_en[2];
	endproperty
	a_mode1_float: assert property (p_mode1_float) else $error("mode 1 release wrong");

	property p_mode2_push;
		mode_of(mode_all[15:0], 1) == MODE_PUSH_PULL
			|=> o_p1_oe[1] && o_p1_out[1] == $past(port1_data_latch[1]) && !o_p1_din_en[1];
	endproperty
	a_mode2_push: assert property (p_mode2_push) else $error("mode 2 push-pull wrong");

	property p_touch_undriven;
		mode_of(mode_all[15:0], 4) == MODE_ALTERNATE
			|=> !o_p1_oe[4] && !o_p1_pullup[4] && !o_p1_din_en[4] && o_touch_key_scan[3];
	endproperty
	a_touch_undriven: assert property (p_touch_undriven) else $error("touch pin not released");

	sequence s_quasi_rise;
		mode_of(mode_all[31:16], 1) == MODE_OPEN_DRAIN_PULLUP && $rose(port3_data_latch[1]);
	endsequence

	// strong drive shows on the two samples after the rise, then the pin falls back to the pull-up
	property p_quasi_boost;
		s_quasi_rise ##1 (mode_of(mode_all[31:16], 1) == MODE_OPEN_DRAIN_PULLUP && port3_data_latch[1])[*2]
			|-> ($past(o_p3_oe[1]) && $past(o_p3_out[1]) && o_p3_oe[1] && o_p3_out[1])
			##1 (!o_p3_oe[1] && o_p3_pullup[1]);
	endproperty
	a_quasi_boost: assert property (p_quasi_boost) else $error("quasi boost length wrong");

	property p_buzzer_pair;
		mode_of(mode_all[31:16], 5) == MODE_ALTERNATE && mode_of(mode_all[31:16], 6) == MODE_ALTERNATE
			|=> o_p3_oe[5] && o_p3_oe[6] && o_p3_out[6] == !o_p3_out[5];
	endproperty
	a_buzzer_pair: assert property (p_buzzer_pair) else $error("buzzer pair not complementary");

	property p_timer2_out;
		mode_of(mode_all[15:0], 0) == MODE_ALTERNATE
			|=> o_p1_oe[0] && o_p1_out[0] == $past(timer2_divided_overflow_out);
	endproperty
	a_timer2_out: assert property (p_timer2_out) else $error("timer2 output not driven");

	property p_high_touch_scan;
		mode_of(mode_all[31:16], 7) == MODE_OPEN_DRAIN_HIZ && port3_data_latch[7]
			|=> o_touch_key_scan[11] && o_touch_key_channels_high[1] == $past(pin_level[15]);
	endproperty
	a_high_touch_scan: assert property (p_high_touch_scan) else $error("high touch channel not scanning");

endmodule

// >>> sim/pin_load_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// pads seen from the board: external pull-up
// ---------------------------------------------
module pin_load_model (
	input  wire logic [7:0] i_out,
	input  wire logic [7:0] i_oe,
	input  wire logic [7:0] i_sink,
	output logic      [7:0] o_level
);
	// an undriven pad rests at the resistor level unless the board sinks it
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			o_level[n] = i_oe[n] ? i_out[n] : ~i_sink[n];
		end
	end
endmodule

// >>> sim/test_quasi_bidir_port_mode_ctrl.sv
`timescale 1ns/1ps
module test_quasi_bidir_port_mode_ctrl;
	import port_mode_pkg::*;
	logic        clk, resetn, wr, rd, rmw;
	logic        tick = 1'b0;
	logic [1:0]  cyc = 2'h0;
	logic [7:0]  addr, wdata, rdata, v, sink, p1_pin, p3_pin, p1_dig, p3_dig;
	logic [9:0]  tk_lo;
	logic [7:0]  p1_out, p1_oe, p1_pu, p1_din, p3_out, p3_oe, p3_pu, p3_din;
	logic [13:0] scan;
	logic [2:0]  e;
	int          fails, n_compared;
	logic [7:0]  ra [6] = '{ADDR_PORT1_DATA_LATCH, ADDR_PORT1_PIN_MODE_LOW, ADDR_PORT1_PIN_MODE_HIGH,
		ADDR_PORT3_PIN_MODE_LOW, ADDR_PORT3_PIN_MODE_HIGH, ADDR_PORT3_DATA_LATCH};
	logic [7:0]  rv [6] = '{RST_PORT1_DATA_LATCH, RST_PORT1_PIN_MODE_LOW, RST_PORT1_PIN_MODE_HIGH,
		RST_PORT3_PIN_MODE_LOW, RST_PORT3_PIN_MODE_HIGH, RST_PORT3_DATA_LATCH};

	quasi_bidir_port_mode_ctrl DUT (.i_clk(clk), .i_resetn(resetn), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
		.i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_rmw(rmw), .o_sfr_rdata(rdata), .i_p1_pin(p1_pin),
		.i_p3_pin(p3_pin), .o_p1_out(p1_out), .o_p1_oe(p1_oe), .o_p1_pullup(p1_pu), .o_p1_din_en(p1_din),
		.o_p3_out(p3_out), .o_p3_oe(p3_oe), .o_p3_pullup(p3_pu), .o_p3_din_en(p3_din),
		.o_p1_digital_in(p1_dig), .o_p3_digital_in(p3_dig), .i_timer2_overflow(tick), .i_timer1_overflow(tick),
		.i_timer2_div_sel(2'h0), .i_timer1_div_sel(2'h1), .i_system_clock_div_sel(2'h2), .i_lcd_segment_a(tick),
		.i_lcd_segment_b(cyc[1]), .o_touch_key_channels_low(tk_lo), .o_touch_key_channels_high(),
		.o_touch_key_scan(scan));
	pin_load_model p1_load (.i_out(p1_out), .i_oe(p1_oe), .i_sink(sink), .o_level(p1_pin));
	pin_load_model p3_load (.i_out(p3_out), .i_oe(p3_oe), .i_sink(8'h00), .o_level(p3_pin));

	// ---------------------------------------------
	// clock, timer ticks and watchdog
	// ---------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// overflow pulse every fourth cycle keeps the dividers moving
	always @(posedge clk) begin
		cyc <= cyc + 2'h1;
		tick <= &cyc;
	end
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		report_and_stop();
	end

	// ---------------------------------------------
	// register access and checking tasks
	// ---------------------------------------------
	task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// rdata holds until the next read, so sampling a cycle late is safe
	task automatic rd_reg(input logic [7:0] a, input logic m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		rmw <= m;
		@(posedge clk);
		rd <= 1'b0;
		rmw <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		v = rdata;
	endtask
	// expected {oe, pullup, din} of a port pin for one mode and latch bit
	function automatic logic [2:0] pad(input logic [1:0] m, input logic l);
		case (m)
			2'h0: return l ? 3'b011 : 3'b100;
			2'h1: return l ? 3'b001 : 3'b100;
			2'h2: return 3'b100;
			default: return 3'b000;
		endcase
	endfunction
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	initial begin
		{resetn, wr, rd, rmw} = '0;
		{addr, wdata, sink} = '0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		// reset values, latches through the read-modify-write path
		for (int i = 0; i < 6; i++) begin
			rd_reg(ra[i], ra[i] == ADDR_PORT1_DATA_LATCH || ra[i] == ADDR_PORT3_DATA_LATCH);
			chk("reset_value", v, rv[i]);
		end
		wr_reg(8'h91, 8'hA5);
		rd_reg(8'h91, 1'b0);
		chk("unmapped", v, 8'h00);
		// pins 0-3 and 4-7 take modes 0,1,2,3 under both latch values
		for (int l = 0; l < 2; l++) begin
			wr_reg(ADDR_PORT1_PIN_MODE_LOW, 8'hE4);
			wr_reg(ADDR_PORT1_PIN_MODE_HIGH, 8'hE4);
			wr_reg(ADDR_PORT1_DATA_LATCH, l ? 8'hFF : 8'h00);
			repeat (3) @(posedge clk);
			@(negedge clk);
			for (int n = 0; n < 8; n++) begin
				e = pad(2'(n % 4), l[0]);
				chk("p1_oe", p1_oe[n], e[2]);
				chk("p1_pullup", p1_pu[n], e[1]);
				chk("p1_din_en", p1_din[n], e[0]);
				chk("p1_out", p1_out[n] & p1_oe[n], e[2] & l[0] & (n % 4 == 2));
			end
			chk("touch_scan", scan, 14'h0011);
			chk("touch_low", tk_lo, 10'h011);
		end
		rd_reg(ADDR_PORT1_PIN_MODE_LOW, 1'b0);
		chk("mode_readback", v, 8'hE4);
		// divided clock pins in mode 3 stay driven with the latch at zero
		wr_reg(ADDR_PORT3_DATA_LATCH, 8'h00);
		wr_reg(ADDR_PORT3_PIN_MODE_HIGH, 8'hFC);
		wr_reg(ADDR_PORT1_PIN_MODE_LOW, 8'hE7);
		repeat (9) @(posedge clk);
		@(negedge clk);
		chk("p3_clock_oe", p3_oe[7:5], 3'b111);
		chk("p3_clock_pullup", p3_pu[7:5], 3'b000);
		chk("p3_inverse", p3_out[6], !p3_out[5]);
		chk("p1_timer2_oe", p1_oe[0], 1'b1);
		chk("lcd_oe", {p3_oe[2], p3_oe[0]}, 2'b11);
		chk("touch_scan", scan, 14'h0011);
		// inputs: mode 1 with latch 1, board sinks pin 2
		wr_reg(ADDR_PORT1_PIN_MODE_LOW, 8'h55);
		wr_reg(ADDR_PORT1_PIN_MODE_HIGH, 8'h55);
		wr_reg(ADDR_PORT1_DATA_LATCH, 8'hFF);
		sink <= 8'h04;
		repeat (5) @(posedge clk);
		rd_reg(ADDR_PORT1_DATA_LATCH, 1'b0);
		chk("pin_read", v, 8'hFB);
		rd_reg(ADDR_PORT1_DATA_LATCH, 1'b1);
		chk("latch_read", v, 8'hFF);
		chk("p1_digital_in", p1_dig, 8'hFB);
		// strong high on a rising latch bit of a quasi pin, then weak
		wr_reg(ADDR_PORT3_DATA_LATCH, 8'hFD);
		repeat (4) @(posedge clk);
		wr_reg(ADDR_PORT3_DATA_LATCH, 8'hFF);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			@(negedge clk);
			chk("quasi_oe", p3_oe[1], i < 2);
			chk("quasi_out", p3_out[1], i < 2);
			chk("quasi_pullup", p3_pu[1], 1'b1);
		end
		// released pins read high once the synchroniser has caught up
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("p3_digital_in", p3_dig, 8'h1A);
		report_and_stop();
	end
endmodule
